// ### logic/ctl_pkg.sv
// shared constants for the control and debug register bank
package ctl_pkg;
  // register indices on the plain register port
  localparam int IDX_W = 3;
  localparam logic [2:0] IDX_MODE = 3'h0;
  localparam logic [2:0] IDX_PBASE = 3'h1;
  localparam logic [2:0] IDX_EXT = 3'h2;
  localparam logic [2:0] IDX_ALIAS_A = 3'h4;
  localparam logic [2:0] IDX_ALIAS_B = 3'h5;
  localparam logic [2:0] IDX_DSTAT = 3'h6;
  localparam logic [2:0] IDX_DCTL = 3'h7;
  localparam logic [2:0] IDX_NONE = 3'h3;
  // extension control fields
  localparam int EXT_VME = 0;
  localparam int EXT_PVI = 1;
  localparam int EXT_TSD = 2;
  localparam int EXT_DE = 3;
  localparam int EXT_PSE = 4;
  localparam int EXT_PAE = 5;
  localparam int EXT_MCE = 6;
  localparam int EXT_PGE = 7;
  localparam int EXT_PCE = 8;
  localparam int EXT_FXSR = 9;
  localparam int EXT_XMM = 10;
  localparam logic [31:0] EXT_KEEP = 32'h000007FF;
  // mode control fields
  localparam int MODE_NE = 5;
  localparam int MODE_WP = 16;
  localparam int MODE_AM = 18;
  localparam int MODE_NW = 29;
  localparam int MODE_CD = 30;
  localparam int MODE_PG = 31;
  // page base control fields
  localparam int PB_PWT = 3;
  localparam int PB_PCD = 4;
  // debug status and control layout
  localparam int BP_N = 4;
  localparam int DS_RSVD = 12;
  localparam logic [31:0] DS_KEEP = 32'hFFFFEFFF;
  localparam logic [31:0] DC_KEEP = 32'hFFFF27FF;
  localparam int DC_TYPE_LSB = 16;
  localparam int DC_TYPE_STRIDE = 4;
  localparam logic [1:0] BP_EXEC = 2'h0;
  localparam logic [1:0] BP_WRITE = 2'h1;
  localparam logic [1:0] BP_IO = 2'h2;
  localparam logic [1:0] BP_RW = 2'h3;
  // values after reset
  localparam logic [31:0] EXT_RST = 32'h00000000;
  localparam logic [31:0] MODE_RST = 32'h00000000;
  localparam logic [31:0] PB_RST = 32'h00000000;
  localparam logic [31:0] DS_RST = 32'h00000000;
  localparam logic [31:0] DC_RST = 32'h00000000;
  // physical address widths
  localparam int PA_NARROW = 32;
  localparam int PA_WIDE = 36;
  localparam int PA_EXTRA = PA_WIDE - PA_NARROW;
  // privilege and descriptor checks
  localparam logic [1:0] CPL_TOP = 2'h0;
  localparam logic [7:0] AR_BAD_A = 8'h80;
  localparam logic [7:0] AR_BAD_B = 8'h00;
  localparam int AR_ACC = 0;
endpackage

// ### logic/bp_type_decode.sv
// breakpoint type field decoder, one set of flags per breakpoint
`timescale 1ns/1ns
module bp_type_decode #(
  parameter int NUM_BP = ctl_pkg::BP_N
) (
  input wire logic [31:0] dctl,
  input wire logic de,
  output logic [NUM_BP-1:0] exec,
  output logic [NUM_BP-1:0] wr,
  output logic [NUM_BP-1:0] io,
  output logic [NUM_BP-1:0] rw
);
  import ctl_pkg::*;

  generate
    for (genvar i = 0; i < NUM_BP; i++) begin : g_bp
      logic [1:0] t;
      assign t = dctl[DC_TYPE_LSB + DC_TYPE_STRIDE * i +: 2];
      assign exec[i] = (t == BP_EXEC);
      assign wr[i] = (t == BP_WRITE);
      // io type left off while extensions are clear
      assign io[i] = (t == BP_IO) && de;
      assign rw[i] = (t == BP_RW);
    end
  endgenerate
endmodule

// ### logic/ctl_regs.sv
// control and debug register bank with flag decode
//
// Function
// - bit 10 of extension control: os handles simd faults
// - bit 9 of extension control: os saves extended state
// - bit 5 set gives 36-bit physical addresses while paging, else 32
// - wide mode opens 4 extra address lines, only while paging
// - bit 7 keeps global tlb entries on task switch or base write
// - bit 8 lets counter reads run at any privilege
// - hardware reset clears extension control to zero
// - timestamp restriction allows timestamp reads at level 0 only
// - two flags enable virtual interrupt flag in v86 and protected
// - debug extensions on: alias index access faults invalid opcode
// - debug extensions off: alias indices reach status and control
// - bit 4 gives 4 MByte pages, or 2 MByte in wide mode
// - machine check raised only while its enable is set
// - numeric error flag selects native float error report
// - write protect blocks supervisor writes to read-only user pages
// - alignment check needs both mask flag and check flag
// - cache on while cache-off clear, off while set
// - no-write-through set stops invalidations and hit write-throughs
// - paging on: page flags drive pins in unpaged cycles
// - debug status bit 12 ignores writes, never reads set
// - breakpoint type 00 is execute, 01 is data write
// - type io breaks on io only with extensions set
// - debug control bits 11, 12, 14, 15 read zero
// - locked accessed-bit update only when bit still clear
// - access rights 80 and 00 are invalid
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ns
module ctl_regs #(
  parameter int NUM_BP = ctl_pkg::BP_N
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [ctl_pkg::IDX_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [1:0] cpl,
  input wire logic ts_read_req,
  input wire logic pmc_read_req,
  input wire logic task_switch,
  input wire logic hw_error,
  input wire logic fpu_error,
  input wire logic misaligned,
  input wire logic align_check,
  input wire logic sup_wr_ro_user,
  input wire logic unpaged_cycle,
  input wire logic desc_load,
  input wire logic [7:0] desc_ar,
  input wire logic [NUM_BP-1:0] bp_hit,
  output logic invalid_opcode_fault,
  output logic ts_read_ok,
  output logic ts_read_fault,
  output logic pmc_read_ok,
  output logic pmc_read_fault,
  output logic tlb_flush_all,
  output logic tlb_flush_nonglobal,
  output logic mach_check_exc,
  output logic fpu_err_native,
  output logic fpu_err_legacy,
  output logic align_fault,
  output logic wp_fault,
  output logic cache_en,
  output logic inval_cycle_en,
  output logic writethru_hit_en,
  output logic page_cache_off_pin,
  output logic page_writethru_pin,
  output logic phys_addr_36,
  output logic [ctl_pkg::PA_EXTRA-1:0] addr_hi_en,
  output logic large_4m_en,
  output logic large_2m_en,
  output logic v86_vif_en,
  output logic prot_vif_en,
  output logic os_simd_fault_support,
  output logic os_state_save_support,
  output logic [NUM_BP-1:0] bp_exec,
  output logic [NUM_BP-1:0] bp_write,
  output logic [NUM_BP-1:0] bp_io,
  output logic [NUM_BP-1:0] bp_rw,
  output logic desc_invalid,
  output logic desc_busy,
  output logic locked_rd,
  output logic locked_wr
);
  import ctl_pkg::*;

  typedef enum logic [1:0] {
    D_IDLE,
    D_RD,
    D_WR
  } desc_state_e;

  logic [31:0] mode_q;
  logic [31:0] pbase_q;
  logic [31:0] ext_q;
  logic [31:0] dstat_q;
  logic [31:0] dstat_d;
  logic [31:0] dctl_q;
  logic [31:0] rd_val;
  logic [2:0] widx;
  logic alias_hit;
  logic paging;
  logic pbase_wr;
  logic desc_start;
  logic desc_bad;
  logic [NUM_BP-1:0] dec_exec;
  logic [NUM_BP-1:0] dec_wr;
  logic [NUM_BP-1:0] dec_io;
  logic [NUM_BP-1:0] dec_rw;
  desc_state_e dstate_q;
  desc_state_e dstate_d;

  function automatic logic is_alias(input logic [2:0] a);
    return (a == IDX_ALIAS_A) || (a == IDX_ALIAS_B);
  endfunction

  // alias indices fold onto status and control unless blocked
  function automatic logic [2:0] map_idx(input logic [2:0] a,
                                         input logic de);
    logic [2:0] r;
    r = a;
    if (is_alias(a)) begin
      if (de) begin
        r = IDX_NONE;
      end else if (a == IDX_ALIAS_A) begin
        r = IDX_DSTAT;
      end else begin
        r = IDX_DCTL;
      end
    end
    return r;
  endfunction

  assign widx = map_idx(reg_addr, ext_q[EXT_DE]);
  assign alias_hit = (reg_wr || reg_rd) && is_alias(reg_addr)
                     && ext_q[EXT_DE];
  assign paging = mode_q[MODE_PG];
  assign pbase_wr = reg_wr && (widx == IDX_PBASE);

  // register storage
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ext_q <= EXT_RST;
    end else if (reg_wr && widx == IDX_EXT) begin
      ext_q <= reg_wdata & EXT_KEEP;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mode_q <= MODE_RST;
    end else if (reg_wr && widx == IDX_MODE) begin
      mode_q <= reg_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pbase_q <= PB_RST;
    end else if (pbase_wr) begin
      pbase_q <= reg_wdata;
    end
  end

  // hit bits set by hardware win over a software write
  always_comb begin
    dstat_d = dstat_q;
    if (reg_wr && widx == IDX_DSTAT) begin
      dstat_d = reg_wdata & DS_KEEP;
    end
    dstat_d[NUM_BP-1:0] = dstat_d[NUM_BP-1:0] | bp_hit;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      dstat_q <= DS_RST;
    end else begin
      dstat_q <= dstat_d;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      dctl_q <= DC_RST;
    end else if (reg_wr && widx == IDX_DCTL) begin
      dctl_q <= reg_wdata & DC_KEEP;
    end
  end

  // read data, valid only in the cycle after the strobe
  always_comb begin
    case (widx)
      IDX_MODE: rd_val = mode_q;
      IDX_PBASE: rd_val = pbase_q;
      IDX_EXT: rd_val = ext_q;
      IDX_DSTAT: rd_val = dstat_q;
      IDX_DCTL: rd_val = dctl_q;
      default: rd_val = 32'h00000000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= rd_val;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      invalid_opcode_fault <= 1'b0;
    end else begin
      invalid_opcode_fault <= alias_hit;
    end
  end

  // privileged instruction gates
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ts_read_ok <= 1'b0;
      ts_read_fault <= 1'b0;
    end else begin
      ts_read_ok <= ts_read_req &&
        (!ext_q[EXT_TSD] || cpl == CPL_TOP);
      ts_read_fault <= ts_read_req &&
        ext_q[EXT_TSD] && cpl != CPL_TOP;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pmc_read_ok <= 1'b0;
      pmc_read_fault <= 1'b0;
    end else begin
      pmc_read_ok <= pmc_read_req &&
        (ext_q[EXT_PCE] || cpl == CPL_TOP);
      pmc_read_fault <= pmc_read_req &&
        !ext_q[EXT_PCE] && cpl != CPL_TOP;
    end
  end

  // tlb flush requests on task switch or page base write
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tlb_flush_all <= 1'b0;
      tlb_flush_nonglobal <= 1'b0;
    end else begin
      tlb_flush_all <= (task_switch || pbase_wr) &&
        !ext_q[EXT_PGE];
      tlb_flush_nonglobal <= (task_switch || pbase_wr) &&
        ext_q[EXT_PGE];
    end
  end

  // exception qualifiers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mach_check_exc <= 1'b0;
      fpu_err_native <= 1'b0;
      fpu_err_legacy <= 1'b0;
      align_fault <= 1'b0;
      wp_fault <= 1'b0;
    end else begin
      mach_check_exc <= hw_error && ext_q[EXT_MCE];
      fpu_err_native <= fpu_error && mode_q[MODE_NE];
      fpu_err_legacy <= fpu_error && !mode_q[MODE_NE];
      align_fault <= misaligned && align_check &&
        mode_q[MODE_AM];
      wp_fault <= sup_wr_ro_user && mode_q[MODE_WP];
    end
  end

  // cache policy levels
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cache_en <= 1'b0;
      inval_cycle_en <= 1'b0;
      writethru_hit_en <= 1'b0;
    end else begin
      cache_en <= !mode_q[MODE_CD];
      inval_cycle_en <= !mode_q[MODE_NW];
      writethru_hit_en <= !mode_q[MODE_NW];
    end
  end

  // page attribute pins for the external cache
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      page_cache_off_pin <= 1'b0;
      page_writethru_pin <= 1'b0;
    end else begin
      page_cache_off_pin <= paging && unpaged_cycle &&
        pbase_q[PB_PCD];
      page_writethru_pin <= paging && unpaged_cycle &&
        pbase_q[PB_PWT];
    end
  end

  // paging mode decode
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      phys_addr_36 <= 1'b0;
      addr_hi_en <= '0;
      large_4m_en <= 1'b0;
      large_2m_en <= 1'b0;
    end else begin
      phys_addr_36 <= paging && ext_q[EXT_PAE];
      addr_hi_en <= {PA_EXTRA{paging && ext_q[EXT_PAE]}};
      large_4m_en <= paging && ext_q[EXT_PSE] &&
        !ext_q[EXT_PAE];
      large_2m_en <= paging && ext_q[EXT_PSE] &&
        ext_q[EXT_PAE];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      v86_vif_en <= 1'b0;
      prot_vif_en <= 1'b0;
      os_simd_fault_support <= 1'b0;
      os_state_save_support <= 1'b0;
    end else begin
      v86_vif_en <= ext_q[EXT_VME];
      prot_vif_en <= ext_q[EXT_PVI];
      os_simd_fault_support <= ext_q[EXT_XMM];
      os_state_save_support <= ext_q[EXT_FXSR];
    end
  end

  bp_type_decode #(
    .NUM_BP(NUM_BP)
  ) u_bp_dec (
    .dctl(dctl_q),
    .de(ext_q[EXT_DE]),
    .exec(dec_exec),
    .wr(dec_wr),
    .io(dec_io),
    .rw(dec_rw)
  );

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bp_exec <= '0;
      bp_write <= '0;
      bp_io <= '0;
      bp_rw <= '0;
    end else begin
      bp_exec <= dec_exec;
      bp_write <= dec_wr;
      bp_io <= dec_io;
      bp_rw <= dec_rw;
    end
  end

  // descriptor load: check rights, then locked update if needed
  assign desc_bad = (desc_ar == AR_BAD_A) ||
                    (desc_ar == AR_BAD_B);
  assign desc_start = desc_load && dstate_q == D_IDLE;

  always_comb begin
    dstate_d = dstate_q;
    case (dstate_q)
      D_IDLE: begin
        if (desc_start && !desc_bad && !desc_ar[AR_ACC]) begin
          dstate_d = D_RD;
        end
      end
      D_RD: dstate_d = D_WR;
      D_WR: dstate_d = D_IDLE;
      default: dstate_d = D_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      dstate_q <= D_IDLE;
    end else begin
      dstate_q <= dstate_d;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      desc_invalid <= 1'b0;
      desc_busy <= 1'b0;
      locked_rd <= 1'b0;
      locked_wr <= 1'b0;
    end else begin
      desc_invalid <= desc_start && desc_bad;
      desc_busy <= dstate_d != D_IDLE;
      locked_rd <= dstate_d == D_RD;
      locked_wr <= dstate_d == D_WR;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  sequence s_rmw;
    locked_rd && !locked_wr ##1 locked_wr ##1 !desc_busy;
  endsequence

  a_ext_reset: assert property (disable iff (1'b0)
    sys_rst |=> ext_q == 32'h00000000)
    else $error("extension control not cleared by reset");
  a_simd_flag: assert property (reg_wr && widx == IDX_EXT
    |-> ##2 os_simd_fault_support == $past(reg_wdata[EXT_XMM], 2))
    else $error("simd fault flag not taken");
  a_ts_gate: assert property (ts_read_req && ext_q[EXT_TSD]
    && cpl != CPL_TOP |=> ts_read_fault && !ts_read_ok)
    else $error("timestamp read allowed off level 0");
  a_alias_fault: assert property (alias_hit
    |=> invalid_opcode_fault && reg_rdata == 32'h00000000)
    else $error("blocked alias access not faulted");
  a_alias_read: assert property (reg_rd && !ext_q[EXT_DE]
    && reg_addr == IDX_ALIAS_A |=> reg_rdata == $past(dstat_q))
    else $error("alias read not routed to status");
  a_stat_rsvd: assert property (!dstat_q[DS_RSVD])
    else $error("status bit 12 set");
  a_ctl_rsvd: assert property ((dctl_q & ~DC_KEEP) == 32'h0)
    else $error("control reserved bit set");
  a_cache_off: assert property (mode_q[MODE_CD] |=> !cache_en)
    else $error("cache left on while disabled");
  a_tlb_global: assert property (task_switch && ext_q[EXT_PGE]
    |=> tlb_flush_nonglobal && !tlb_flush_all)
    else $error("global entries flushed");
  a_desc_rmw: assert property (desc_start && !desc_bad
    && !desc_ar[AR_ACC] |=> s_rmw)
    else $error("locked update sequence wrong");
  a_desc_skip: assert property (desc_start && desc_ar[AR_ACC]
    |=> !locked_rd && !desc_busy)
    else $error("locked update with accessed set");
  a_desc_bad: assert property (desc_start && desc_bad
    |=> desc_invalid && !locked_rd)
    else $error("invalid rights accepted");
endmodule

// ### verification/ctl_regs_tb.sv
// self-checking bench for the control and debug register bank
`timescale 1ns/1ns
module ctl_regs_tb;
  import ctl_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [IDX_W-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [1:0] cpl = 2'h0;
  logic [7:0] ev = 8'h00;
  logic align_check = 1'b0;
  logic unpaged_cycle = 1'b0;
  logic [7:0] desc_ar = 8'h00;
  logic [BP_N-1:0] bp_hit = '0;
  logic iof, tso, tsf, pmo, pmf, fla, fln, mach_check_en, fen, fel, alf, wpf;
  logic cen, ive, whe, pcp, pwp, p36, l4m, l2m, vvif, pvif, osx, osf;
  logic [PA_EXTRA-1:0] ahe;
  logic [BP_N-1:0] bex, bwr, bio, brw;
  logic dinv, dbusy, lrd, lwr;
  logic [31:0] rd_v;
  logic [7:0] ars [4] = '{8'h92, 8'h93, 8'h80, 8'h00};
  logic [2:0] exp_a [4] = '{3'h6, 3'h0, 3'h1, 3'h1};
  logic [1:0] exp_b [4] = '{2'h3, 2'h0, 2'h0, 2'h0};
  int mismatches = 0;
  int total_checks = 0;

  always #50 clock = ~clock;

  ctl_regs #(.NUM_BP(BP_N)) dut_u (
    .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cpl(cpl), .ts_read_req(ev[0]),
    .pmc_read_req(ev[1]), .task_switch(ev[2]), .hw_error(ev[3]),
    .fpu_error(ev[4]), .misaligned(ev[5]), .align_check(align_check),
    .sup_wr_ro_user(ev[6]), .unpaged_cycle(unpaged_cycle),
    .desc_load(ev[7]), .desc_ar(desc_ar), .bp_hit(bp_hit),
    .invalid_opcode_fault(iof), .ts_read_ok(tso), .ts_read_fault(tsf),
    .pmc_read_ok(pmo), .pmc_read_fault(pmf), .tlb_flush_all(fla),
    .tlb_flush_nonglobal(fln), .mach_check_exc(mach_check_en),
    .fpu_err_native(fen), .fpu_err_legacy(fel), .align_fault(alf),
    .wp_fault(wpf), .cache_en(cen), .inval_cycle_en(ive),
    .writethru_hit_en(whe), .page_cache_off_pin(pcp),
    .page_writethru_pin(pwp), .phys_addr_36(p36), .addr_hi_en(ahe),
    .large_4m_en(l4m), .large_2m_en(l2m), .v86_vif_en(vvif),
    .prot_vif_en(pvif), .os_simd_fault_support(osx),
    .os_state_save_support(osf), .bp_exec(bex), .bp_write(bwr),
    .bp_io(bio), .bp_rw(brw), .desc_invalid(dinv), .desc_busy(dbusy),
    .locked_rd(lrd), .locked_wr(lwr)
  );

  function automatic logic [31:0] b(input int n);
    return 32'h1 << n;
  endfunction

  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [IDX_W-1:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [IDX_W-1:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask

  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask

  // one-cycle event pulse, answer sampled in the following cycle
  task automatic pulse(input logic [7:0] m);
    @(posedge clock);
    ev <= m;
    @(posedge clock);
    ev <= 8'h00;
    #1;
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #2000000;
    mismatches++;
    stop_test();
  end

  initial begin
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    settle();
    check("cache levels", 32'h7, {cen, ive, whe});
    for (int i = 0; i < 8; i++) begin
      rd(3'(i));
      check("reset read", 32'h0, rd_v);
    end
    wr(IDX_EXT, 32'hFFFFFFFF);
    rd(IDX_EXT);
    check("ext", EXT_KEEP, rd_v);
    check("simd", 32'h1, osx);
    check("save", 32'h1, osf);
    check("vif", 32'h3, {vvif, pvif});
    // reset in mid-run with every extension flag set
    @(posedge clock);
    sys_rst <= 1'b1;
    @(posedge clock);
    sys_rst <= 1'b0;
    rd(IDX_EXT);
    check("ext after reset", 32'h0, rd_v);
    wr(IDX_EXT, b(EXT_PAE) | b(EXT_PSE));
    settle();
    check("wide no paging", 32'h0, {p36, ahe});
    wr(IDX_MODE, b(MODE_PG));
    settle();
    check("wide", 32'h1F, {p36, ahe});
    check("large wide", 32'h1, {l4m, l2m});
    wr(IDX_EXT, b(EXT_PSE));
    settle();
    check("narrow", 32'h0, {p36, ahe});
    check("large", 32'h2, {l4m, l2m});
    pulse(8'h04);
    check("flush plain", 32'h2, {fla, fln});
    wr(IDX_EXT, b(EXT_PGE));
    settle();
    pulse(8'h04);
    check("flush global", 32'h1, {fla, fln});
    wr(IDX_PBASE, b(PB_PCD) | b(PB_PWT));
    #1 check("flush base", 32'h1, {fla, fln});
    settle();
    check("pins paged", 32'h0, {pcp, pwp});
    @(posedge clock);
    unpaged_cycle <= 1'b1;
    settle();
    check("pins unpaged", 32'h3, {pcp, pwp});
    wr(IDX_MODE, 32'h0);
    settle();
    check("pins no paging", 32'h0, {pcp, pwp});
    @(posedge clock);
    cpl <= 2'h3;
    pulse(8'h03);
    check("reads open", 32'h9, {tso, tsf, pmo, pmf});
    wr(IDX_EXT, b(EXT_TSD) | b(EXT_PCE));
    settle();
    pulse(8'h03);
    check("reads lvl3", 32'h6, {tso, tsf, pmo, pmf});
    @(posedge clock);
    cpl <= 2'h0;
    pulse(8'h03);
    check("reads lvl0", 32'hA, {tso, tsf, pmo, pmf});
    @(posedge clock);
    align_check <= 1'b1;
    pulse(8'h78);
    check("faults off", 32'h4, {mach_check_en, fen, fel, alf, wpf});
    wr(IDX_MODE, b(MODE_CD));
    settle();
    check("cache off", 32'h3, {cen, ive, whe});
    wr(IDX_EXT, b(EXT_MCE));
    wr(IDX_MODE, b(MODE_NE) | b(MODE_WP) | b(MODE_AM) | b(MODE_NW));
    settle();
    check("no writethru", 32'h4, {cen, ive, whe});
    pulse(8'h78);
    check("faults on", 32'h1B, {mach_check_en, fen, fel, alf, wpf});
    @(posedge clock);
    align_check <= 1'b0;
    pulse(8'h20);
    check("align mask only", 32'h0, alf);
    wr(IDX_ALIAS_A, 32'hFFFFFFFF);
    rd(IDX_DSTAT);
    check("status via alias", DS_KEEP, rd_v);
    wr(IDX_ALIAS_B, 32'hFFFFFFFF);
    rd(IDX_DCTL);
    check("control via alias", DC_KEEP, rd_v);
    rd(IDX_ALIAS_B);
    check("alias read", DC_KEEP, rd_v);
    check("no fault", 32'h0, iof);
    wr(IDX_DCTL, 32'h32100000);
    wr(IDX_EXT, b(EXT_DE));
    wr(IDX_ALIAS_A, 32'h0);
    #1 check("alias write fault", 32'h1, iof);
    rd(IDX_ALIAS_A);
    check("alias read zero", 32'h0, rd_v);
    check("alias read fault", 32'h1, iof);
    rd(IDX_DSTAT);
    check("status kept", DS_KEEP, rd_v);
    settle();
    check("types ext", 32'h1248, {bex, bwr, bio, brw});
    wr(IDX_EXT, 32'h0);
    settle();
    check("types plain", 32'h1208, {bex, bwr, bio, brw});
    // hit in the same cycle as a status write must survive it
    fork
      wr(IDX_DSTAT, 32'h00001000);
      begin
        @(posedge clock);
        bp_hit <= 4'h5;
        @(posedge clock);
        bp_hit <= '0;
      end
    join
    rd(IDX_DSTAT);
    check("hit beats write", 32'h5, rd_v);
    foreach (ars[i]) begin
      desc_ar <= ars[i];
      pulse(8'h80);
      check("desc first", exp_a[i], {lrd, dbusy, dinv});
      @(posedge clock);
      #1 check("desc second", exp_b[i], {lwr, dbusy});
      @(posedge clock);
    end
    stop_test();
  end
endmodule
